// ### dscp_port.sv
// dscp_port: serial command port of a single-channel current-output converter.
// assumes: pins arrive asynchronously to CLK; serial clock well below CLK/4 so edges are seen.
`timescale 1ns/1ps
//Contract
// - 24-bit shift register takes serial input MSB first on serial clock rise.
// - frame is address byte in bits 23..16, data word in bits 15..0.
// - every load strobe rise commits the last 24 bits to the addressed target.
// - shifting continues whatever level the load strobe has.
// - address 00 nop, 01 code, 02 readback, 55 configuration, 56 reset.
// - chaining is on only while the chain-enable configuration bit is set.
// - in chain mode, past 24 pulses, shifted-out bits appear on serial output.
// - serial output changes on falling serial clock edge for next rising edge.
// - one shared strobe rise commits the frame in every chained device.
// - readback selector in data bits 1..0: status, code, configuration.
// - serial output floats unless readback or chain output is active.
// - readback commit drives serial output; next strobe after shifting floats it.
// - frame after readback is a nop, during which selected register shifts out.
// - top four code bits drive 15 segments, rest drive the binary ladder.
// - 12-bit variant uses data bits 15..4 and ignores bits 3..0.
// - power-on clears every register but sets the calibration reload flag, output disabled.
// - reset target acts like power-on reset and reloads calibration.
module dscp_port #(
   parameter int RES = 16
) (
   input  wire logic                             CLK,
   input  wire logic                             RST_B,
   input  wire logic                             SERIAL_CLK,
   input  wire logic                             SERIAL_IN,
   input  wire logic                             LOAD,
   output logic                                  SERIAL_OUT,
   output logic                                  SERIAL_OUT_OE,
   output logic      [RES-1:0]                   OUTPUT_CODE,
   output logic      [dscp_pkg::WORD_BITS-1:0]   CONFIGURATION,
   output logic                                  OUTPUT_ENABLE,
   output logic      [dscp_pkg::SEG_COUNT-1:0]   SEGMENT_SWITCHES,
   output logic      [dscp_pkg::LADDER_MAX-1:0]  LADDER_SWITCHES,
   output logic                                  CAL_RELOAD
);

   typedef enum logic [1:0] {
      RB_IDLE  = 2'b00,
      RB_ARMED = 2'b01,
      RB_SHIFT = 2'b10
   } dscp_rb_type;

   typedef struct packed {
      logic                                  sclk_p;
      logic                                  load_p;
      logic [dscp_pkg::FRAME_BITS-1:0]       sr;
      logic [dscp_pkg::CNT_W-1:0]            cnt;
      logic [dscp_pkg::WORD_BITS-1:0]        code;
      logic [dscp_pkg::WORD_BITS-1:0]        cfg;
      dscp_rb_type                           rb;
      logic [dscp_pkg::FRAME_BITS-1:0]       rb_sr;
      logic                                  serial_out;
      logic                                  sdo_oe;
      logic [dscp_pkg::SEG_COUNT-1:0]        seg;
      logic [dscp_pkg::LADDER_MAX-1:0]       lad;
      logic                                  cal;
   } dscp_state_type;

   dscp_state_type s_q;
   dscp_state_type s_d;

   logic [dscp_pkg::PIN_COUNT-1:0]        pins_raw;
   logic [dscp_pkg::PIN_COUNT-1:0]        pins;
   logic                                  sclk;
   logic                                  serial_in;
   logic                                  load;
   logic                                  sclk_rise;
   logic                                  sclk_fall;
   logic                                  load_rise;
   logic [dscp_pkg::FRAME_BITS-1:0]       frame;
   logic [7:0]                            addr;
   logic [dscp_pkg::WORD_BITS-1:0]        word;
   logic [RES-1:0]                        dac_code;
   logic [dscp_pkg::SEG_COUNT-1:0]        seg_next;
   logic [dscp_pkg::LADDER_MAX-1:0]       lad_next;
   logic                                  chain_on;

   // keep only the resolution bits, left-aligned in the data word
   function automatic logic [dscp_pkg::WORD_BITS-1:0] trim_code(input logic [dscp_pkg::WORD_BITS-1:0] w);
      logic [dscp_pkg::WORD_BITS-1:0] m;
      m = {dscp_pkg::WORD_BITS{1'b1}} << (dscp_pkg::RES_FULL - RES);
      return w & m;
   endfunction

   // register chosen for readback, padded to a whole frame
   function automatic logic [dscp_pkg::FRAME_BITS-1:0] read_word(input logic [1:0] sel,
                                                                 input logic [dscp_pkg::WORD_BITS-1:0] c,
                                                                 input logic [dscp_pkg::WORD_BITS-1:0] f);
      logic [dscp_pkg::WORD_BITS-1:0] w;
      case (sel)
         dscp_pkg::SEL_STATUS: w = dscp_pkg::WORD_RESET;
         dscp_pkg::SEL_CODE:   w = c;
         dscp_pkg::SEL_CONFIG: w = f;
         default:              w = dscp_pkg::WORD_RESET;
      endcase
      return {dscp_pkg::READ_PAD, w};
   endfunction

   assign pins_raw[dscp_pkg::PIN_SCLK] = SERIAL_CLK;
   assign pins_raw[dscp_pkg::PIN_SERIAL_IN] = SERIAL_IN;
   assign pins_raw[dscp_pkg::PIN_LOAD] = LOAD;

   dscp_sync #(
      .W (dscp_pkg::PIN_COUNT)
   ) u_sync (
      .clk   (CLK),
      .rst_b (RST_B),
      .d     (pins_raw),
      .q     (pins)
   );

   assign sclk      = pins[dscp_pkg::PIN_SCLK];
   assign serial_in      = pins[dscp_pkg::PIN_SERIAL_IN];
   assign load      = pins[dscp_pkg::PIN_LOAD];
   assign sclk_rise = sclk & ~s_q.sclk_p;
   assign sclk_fall = ~sclk & s_q.sclk_p;
   assign load_rise = load & ~s_q.load_p;

   // the frame committed by a strobe includes a bit arriving in the same cycle
   assign frame = sclk_rise ? {s_q.sr[dscp_pkg::FRAME_BITS-2:0], serial_in} : s_q.sr;
   assign addr  = frame[dscp_pkg::ADDR_MSB:dscp_pkg::ADDR_LSB];
   assign word  = frame[dscp_pkg::DATA_MSB:dscp_pkg::DATA_LSB];

   assign chain_on = s_q.cfg[dscp_pkg::CFG_CHAIN_BIT];

   assign dac_code = s_q.code[dscp_pkg::WORD_BITS-1 -: RES];

   dscp_core_map #(
      .RES (RES)
   ) u_map (
      .code     (dac_code),
      .segments (seg_next),
      .ladder   (lad_next)
   );

   always_comb begin
      s_d        = s_q;
      s_d.sclk_p = sclk;
      s_d.load_p = load;
      s_d.cal    = 1'b0;
      s_d.seg    = seg_next;
      s_d.lad    = lad_next;

      // shifting never looks at the strobe level
      if (sclk_rise) begin
         s_d.sr = frame;
         if (s_q.cnt != dscp_pkg::CNT_MAX) begin
            s_d.cnt = s_q.cnt + 6'h01;
         end
         if (s_q.rb == RB_ARMED) begin
            s_d.rb = RB_SHIFT;
         end
      end

      // outgoing bit moves on the falling edge so the next device samples it stable
      if (sclk_fall) begin
         if (s_q.rb != RB_IDLE) begin
            s_d.rb_sr = {s_q.rb_sr[dscp_pkg::FRAME_BITS-2:0], 1'b0};
            s_d.serial_out   = s_q.rb_sr[dscp_pkg::FRAME_BITS-2];
         end else if (chain_on && s_q.cnt >= dscp_pkg::CNT_FRAME) begin
            s_d.serial_out    = s_q.sr[dscp_pkg::FRAME_BITS-1];
            s_d.sdo_oe = 1'b1;
         end
      end

      if (!chain_on && s_q.rb == RB_IDLE) begin
         s_d.sdo_oe = 1'b0;
      end

      // one strobe edge commits the frame here and in every chained device
      if (load_rise) begin
         s_d.cnt = '0;
         if (s_q.rb == RB_SHIFT || s_q.rb == RB_ARMED) begin
            s_d.rb     = RB_IDLE;
            s_d.sdo_oe = 1'b0;
            s_d.serial_out    = 1'b0;
         end else if (!chain_on) begin
            s_d.sdo_oe = 1'b0;
         end
         case (addr)
            dscp_pkg::ADDR_NOP: begin
               s_d.code = s_q.code;
            end
            dscp_pkg::ADDR_CODE: begin
               s_d.code = trim_code(word);
            end
            dscp_pkg::ADDR_READ: begin
               s_d.rb_sr  = read_word(word[dscp_pkg::SEL_MSB:0], s_q.code, s_q.cfg);
               s_d.serial_out    = s_d.rb_sr[dscp_pkg::FRAME_BITS-1];
               s_d.sdo_oe = 1'b1;
               s_d.rb     = RB_ARMED;
            end
            dscp_pkg::ADDR_CONFIG: begin
               s_d.cfg = word;
               if (!word[dscp_pkg::CFG_CHAIN_BIT] && s_d.rb == RB_IDLE) begin
                  s_d.sdo_oe = 1'b0;
               end
            end
            dscp_pkg::ADDR_RESET: begin
               s_d.code   = dscp_pkg::WORD_RESET;
               s_d.cfg    = dscp_pkg::WORD_RESET;
               s_d.rb     = RB_IDLE;
               s_d.rb_sr  = dscp_pkg::FRAME_RESET;
               s_d.serial_out    = 1'b0;
               s_d.sdo_oe = 1'b0;
               s_d.cal    = 1'b1;
            end
            default: begin
               s_d.cfg = s_q.cfg;
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         s_q     <= '0;
         s_q.rb  <= RB_IDLE;
         s_q.cal <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign SERIAL_OUT       = s_q.serial_out;
   assign SERIAL_OUT_OE    = s_q.sdo_oe;
   assign OUTPUT_CODE      = dac_code;
   assign CONFIGURATION    = s_q.cfg;
   assign OUTPUT_ENABLE    = s_q.cfg[dscp_pkg::CFG_OUTEN_BIT];
   assign SEGMENT_SWITCHES = s_q.seg;
   assign LADDER_SWITCHES  = s_q.lad;
   assign CAL_RELOAD       = s_q.cal;

endmodule

// ### dscp_pkg.sv
// dscp_pkg: constants shared by the serial command port of the current-output converter.
// assumes: every file refers to names here as dscp_pkg::name, nothing is imported.
package dscp_pkg;

   // frame layout
   localparam int          FRAME_BITS  = 24;
   localparam int          ADDR_MSB    = 23;
   localparam int          ADDR_LSB    = 16;
   localparam int          DATA_MSB    = 15;
   localparam int          DATA_LSB    = 0;
   localparam int          WORD_BITS   = 16;
   localparam int          SEL_MSB     = 1;

   // rising-edge counter saturates just past one frame
   localparam int          CNT_W       = 6;
   localparam logic [5:0]  CNT_FRAME   = 6'h18;
   localparam logic [5:0]  CNT_MAX     = 6'h19;

   // address byte targets
   localparam logic [7:0]  ADDR_NOP    = 8'h00;
   localparam logic [7:0]  ADDR_CODE   = 8'h01;
   localparam logic [7:0]  ADDR_READ   = 8'h02;
   localparam logic [7:0]  ADDR_CONFIG = 8'h55;
   localparam logic [7:0]  ADDR_RESET  = 8'h56;

   // readback selector in the two low data bits
   localparam logic [1:0]  SEL_STATUS  = 2'h0;
   localparam logic [1:0]  SEL_CODE    = 2'h1;
   localparam logic [1:0]  SEL_CONFIG  = 2'h2;

   // configuration fields
   localparam int          CFG_CHAIN_BIT = 3;
   localparam int          CFG_OUTEN_BIT = 12;

   // reset values: power-on clears everything but the calibration reload flag
   localparam logic [15:0] WORD_RESET  = 16'h0000;
   localparam logic [23:0] FRAME_RESET = 24'h000000;
   localparam logic [7:0]  READ_PAD    = 8'h00;

   // converter core split
   localparam int          SEG_BITS    = 4;
   localparam int          SEG_COUNT   = 15;
   localparam int          LADDER_MAX  = 12;
   localparam int          RES_FULL    = 16;

   // pin synchroniser inputs: serial clock, serial data, load strobe
   localparam int          PIN_COUNT   = 3;
   localparam int          PIN_SCLK    = 0;
   localparam int          PIN_SERIAL_IN    = 1;
   localparam int          PIN_LOAD    = 2;

endpackage

// ### dscp_sync.sv
// dscp_sync: two-flop synchroniser for a group of asynchronous pin levels.
// assumes: inputs are independent levels; no output is a bus word needing coherence.
`timescale 1ns/1ps
module dscp_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } dscp_sync_type;

   dscp_sync_type s_q;
   dscp_sync_type s_d;

   always_comb begin
      s_d        = s_q;
      s_d.meta   = d;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign q = s_q.stable;

endmodule

// ### dscp_core_map.sv
// dscp_core_map: splits a converter code into thermometer segments and binary ladder bits.
// assumes: caller registers the outputs; RES between 5 and 16.
`timescale 1ns/1ps
module dscp_core_map #(
   parameter int RES = 16
) (
   input  wire logic [RES-1:0]                   code,
   output logic      [dscp_pkg::SEG_COUNT-1:0]  segments,
   output logic      [dscp_pkg::LADDER_MAX-1:0] ladder
);

   localparam int LAD = RES - dscp_pkg::SEG_BITS;

   logic [dscp_pkg::SEG_BITS-1:0] top;

   always_comb begin
      top = code[RES-1 -: dscp_pkg::SEG_BITS];
      // segment i closes once the top nibble exceeds i
      for (int i = 0; i < dscp_pkg::SEG_COUNT; i++) begin
         segments[i] = (top > i[dscp_pkg::SEG_BITS-1:0]);
      end
      ladder = '0;
      ladder[LAD-1:0] = code[LAD-1:0];
   end

endmodule

// ### dscp_port_assertions.sv
// dscp_port_assertions: pin-level timing and value checks on the serial command port.
// assumes: link half periods of at least 3 CLK; load strobe high for several CLK.
`timescale 1ns/1ps
module dscp_chk #(
   parameter int RES = 16
) (
   input wire logic          CLK,
   input wire logic          RST_B,
   input wire logic          SERIAL_CLK,
   input wire logic          SERIAL_IN,
   input wire logic          LOAD,
   input wire logic          SERIAL_OUT,
   input wire logic          SERIAL_OUT_OE,
   input wire logic [RES-1:0] OUTPUT_CODE,
   input wire logic [15:0]    CONFIGURATION,
   input wire logic          OUTPUT_ENABLE,
   input wire logic [14:0]    SEGMENT_SWITCHES,
   input wire logic [11:0]    LADDER_SWITCHES,
   input wire logic          CAL_RELOAD
);
   // recent strobe samples: commits land 3-4 CLK after the pin rises
   logic [7:0] load_h;
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         load_h <= 8'h00;
      end else begin
         load_h <= {load_h[6:0], LOAD};
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   AST_RESET_CLEAR: assert property ($rose(RST_B) |->
         OUTPUT_CODE == '0 && CONFIGURATION == '0 && !SERIAL_OUT_OE)
      else $error("registers not clear after reset");
   AST_CAL_PULSE: assert property (CAL_RELOAD |=> !CAL_RELOAD)
      else $error("reload pulse too long");
   AST_CAL_CLEAR: assert property (CAL_RELOAD |-> ##[0:1] (OUTPUT_CODE == '0 && CONFIGURATION == '0))
      else $error("registers not cleared with reload");
   AST_REG_ON_LOAD: assert property (
         ($changed(OUTPUT_CODE) || $changed(CONFIGURATION)) |-> (|load_h))
      else $error("register changed without strobe");
   AST_SEG: assert property (
         SEGMENT_SWITCHES == 15'h7FFF >> (5'h0F - 5'($past(OUTPUT_CODE[RES-1 -: 4]))))
      else $error("segment decode wrong");
   AST_LADDER: assert property (LADDER_SWITCHES == 12'($past(OUTPUT_CODE[RES-5:0])))
      else $error("ladder bits wrong");
   AST_OE_RISE: assert property (
         $rose(SERIAL_OUT_OE) |-> (|load_h) || CONFIGURATION[3])
      else $error("output driven without cause");
   AST_OE_FALL: assert property ($fell(SERIAL_OUT_OE) |-> (|load_h))
      else $error("output released without strobe");
   AST_SO_EDGE: assert property (
         $changed(SERIAL_OUT) |-> (|load_h) || !(SERIAL_CLK || $past(SERIAL_CLK) || $past(SERIAL_CLK, 2)))
      else $error("serial output moved off the falling edge");
   CVR_READBACK: cover property ($rose(SERIAL_OUT_OE) && !CONFIGURATION[3]);
   CVR_CHAIN: cover property ($rose(SERIAL_OUT_OE) && CONFIGURATION[3]);
   CVR_CAL: cover property ($fell(CAL_RELOAD));
endmodule
bind dscp_port dscp_chk #(.RES(RES)) i_dscp_chk (.CLK(CLK), .RST_B(RST_B), .SERIAL_CLK(SERIAL_CLK),
   .SERIAL_IN(SERIAL_IN), .LOAD(LOAD), .SERIAL_OUT(SERIAL_OUT), .SERIAL_OUT_OE(SERIAL_OUT_OE),
   .OUTPUT_CODE(OUTPUT_CODE), .CONFIGURATION(CONFIGURATION), .OUTPUT_ENABLE(OUTPUT_ENABLE),
   .SEGMENT_SWITCHES(SEGMENT_SWITCHES), .LADDER_SWITCHES(LADDER_SWITCHES), .CAL_RELOAD(CAL_RELOAD));

// ### dscp_host.sv
// dscp_host: host side of the serial link, drives clock, data and strobe.
// assumes: CLK is the bench clock; link half period is 8 CLK, a 64 ns period.
`timescale 1ns/1ps
module dscp_host (
   input  wire logic CLK,
   input  wire logic SERIAL_OUT,
   output logic      SERIAL_CLK,
   output logic      SERIAL_IN,
   output logic      LOAD
);
   initial begin
      SERIAL_CLK = 1'b0;
      SERIAL_IN  = 1'b0;
      LOAD       = 1'b0;
   end
   // clock idles low between frames: matches the port's edge detector after reset,
   // and the first readback bit set up at the commit is sampled on the first rise
   task automatic shift(input logic [23:0] w, output logic [23:0] r);
      @(posedge CLK);
      for (int i = 23; i >= 0; i--) begin
         SERIAL_IN <= w[i];
         repeat (8) @(posedge CLK);
         SERIAL_CLK <= 1'b1;
         r[i] = SERIAL_OUT;
         repeat (8) @(posedge CLK);
         SERIAL_CLK <= 1'b0;
      end
      SERIAL_IN <= ~w[0];
   endtask
   task automatic load();
      @(posedge CLK) LOAD <= 1'b1;
      repeat (8) @(posedge CLK);
      LOAD <= 1'b0;
      repeat (8) @(posedge CLK);
   endtask
endmodule

// ### tb_top.sv
// tb_top: self-checking bench comparing the serial command port with a register model.
// assumes: host model in dscp_host.sv, checker bound from its own file.
`timescale 1ns/1ps
module tb_top;
   logic        clk, rst_b, sclk, sin, load, sout, sout_oe, out_en, cal;
   logic [15:0] code, cfg, lfsr;
   logic [14:0] seg;
   logic [11:0] lad, code12;
   logic        so_pin;
   logic [23:0] r, w;
   logic [7:0]  bad [4] = '{8'h03, 8'h54, 8'h57, 8'hFF};
   int          fails, comparisons, cal_seen, m_code, m_cfg;
   int          rb_q[$];
   dscp_port i_dscp_port (.CLK(clk), .RST_B(rst_b), .SERIAL_CLK(sclk), .SERIAL_IN(sin), .LOAD(load),
      .SERIAL_OUT(sout), .SERIAL_OUT_OE(sout_oe), .OUTPUT_CODE(code), .CONFIGURATION(cfg),
      .OUTPUT_ENABLE(out_en), .SEGMENT_SWITCHES(seg), .LADDER_SWITCHES(lad), .CAL_RELOAD(cal));
   // 12-bit variant on the same pins, only its code register is compared
   dscp_port #(.RES(12)) i_dscp_port_12 (.CLK(clk), .RST_B(rst_b), .SERIAL_CLK(sclk), .SERIAL_IN(sin),
      .LOAD(load), .SERIAL_OUT(), .SERIAL_OUT_OE(), .OUTPUT_CODE(code12), .CONFIGURATION(),
      .OUTPUT_ENABLE(), .SEGMENT_SWITCHES(), .LADDER_SWITCHES(), .CAL_RELOAD());
   // a released serial output shows the inverse of its last bit, so a sample taken while floating is caught
   assign so_pin = sout_oe ? sout : ~sout;
   dscp_host i_dscp_host (.CLK(clk), .SERIAL_OUT(so_pin), .SERIAL_CLK(sclk), .SERIAL_IN(sin), .LOAD(load));
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
      comparisons++;
      if (s !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // one committed frame; the model tracks registers and pending readbacks
   task automatic send(input logic [23:0] f);
      i_dscp_host.shift(f, r);
      i_dscp_host.load();
      if (rb_q.size() > 0) chk("readback", 24'(rb_q.pop_front()), r);
      case (f[23:16])
         8'h01: m_code = f[15:0];
         8'h02: rb_q.push_back(f[1:0] == 2'h1 ? m_code : f[1:0] == 2'h2 ? m_cfg : 0);
         8'h55: m_cfg = f[15:0];
         8'h56: begin
            m_code = 0;
            m_cfg  = 0;
         end
         default: ;
      endcase
      chk("code", 24'(m_code), code);
      chk("code12", 24'(m_code[15:4]), code12);
      chk("config", 24'(m_cfg), cfg);
      chk("enable", 24'(m_cfg[12]), out_en);
      chk("segments", 24'((32'h1 << m_code[15:12]) - 32'h1), seg);
      chk("ladder", 24'(m_code[11:0]), lad);
      chk("drive", 24'(rb_q.size()), sout_oe);
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) if (cal) cal_seen++;
   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      end_of_test();
   end
   initial begin
      rst_b = 1'b0;
      lfsr = 16'h072F;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      send(24'h000000);
      for (int i = 0; i < 4; i++) begin
         lfsr = nxt(lfsr);
         send({8'h01, lfsr});
         lfsr = nxt(lfsr);
         send({8'h55, lfsr & 16'hFFF7});
         // back-to-back readbacks: each strobe ends one and arms the next
         for (int s = 0; s < 4; s++) send({22'h008000, 2'(s)});
         send(24'h000000);
         send({bad[i], lfsr});
         send({8'h00, ~lfsr});
      end
      w = {8'h01, lfsr};
      i_dscp_host.shift(w, r);
      i_dscp_host.shift(24'h000000, r);
      chk("drive", 24'h000000, sout_oe);
      i_dscp_host.load();
      i_dscp_host.shift(24'h550008, r);
      i_dscp_host.load();
      i_dscp_host.shift(w, r);
      i_dscp_host.shift(24'h550000, r);
      chk("chain", w, r);
      i_dscp_host.load();
      m_cfg = 0;
      send(24'h000000);
      cal_seen = 0;
      send(24'h560000);
      chk("reload", 24'h000001, 24'(cal_seen));
      end_of_test();
   end
endmodule
